/* hdl/smbc_defines.vh */
// Overview of operation
// - eight banks, each configurable as 8, 16 or 32 bits wide, any memory type
// - one bank select output per bank, polarity programmable per bank
// - only addresses with top three bits 010 are external accesses
// - address bits 28 to 26 pick the bank and assert its select
// - address bits 25 and 24 ignored, so those values mirror the bank
// - address bits 23 to 0 drive the 24-bit external address
// - active-low write strobe on writes, active-low output enable on reads
// - four byte-lane strobes mark active bytes of the 32-bit data bus
// - per-bank setting lets byte-lane strobes assert on reads too
// - per-bank turnaround idle count from one to 16 cycles
// - read followed by write on the same bank inserts the idle cycles
// - separate read and write wait-state counts up to 31 cycles
// - burst ROM uses first-beat and subsequent-beat wait counts
// - burst reads enabled or disabled per bank
// - page-mode reads on clockless memories via subsequent-beat timing
// - write-protected bank never sees a write strobe
// - everything runs on one clock, counts in clock periods
`ifndef SMBC_DEFINES_VH
`define SMBC_DEFINES_VH
`define SMBC_BASE_HI 31
`define SMBC_BASE_LO 29
`define SMBC_BASE_VAL 3'b010
`define SMBC_BANK_HI 28
`define SMBC_BANK_LO 26
`define SMBC_ADDR_HI 23
`define SMBC_WIDTH_8 2'b00
`define SMBC_WIDTH_16 2'b01
`define SMBC_WIDTH_32 2'b10
`define SMBC_WS_W 5
`define SMBC_IDLE_W 4
`endif

/* hdl/smbc_cfg_mem.v */
`timescale 1ns/100ps
// per-bank configuration store, registered read
module smbc_cfg_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock
  input wire i_sys_clk,
  // write port
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [WIDTH-1:0] i_wdata,
  // read port
  input wire [AW-1:0] i_raddr,
  output reg [WIDTH-1:0] o_rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  always @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // smbc_cfg_mem

/* hdl/smbc_ctrl.v */
`timescale 1ns/100ps
`include "smbc_defines.vh"
// config word layout (bits):
// [1:0] width, [2] unused (select polarity from i_cs_pol), [3] read byte lanes, [7:4] idle-1,
// [12:8] read wait, [17:13] write wait, [22:18] first burst wait,
// [27:23] subsequent burst wait, [28] burst enable, [29] write protect
module smbc_ctrl #(
  parameter NBANK = 8,
  parameter CFG_W = 30
) (
  // clock and reset
  input wire i_sys_clk,
  input wire i_rst_b,
  // configuration port
  input wire i_cfg_we,
  input wire [2:0] i_cfg_bank,
  input wire [CFG_W-1:0] i_cfg_data,
  input wire [NBANK-1:0] i_cs_pol,
  // system bus request
  input wire i_req,
  input wire i_write,
  input wire [31:0] i_addr,
  input wire [3:0] i_byte_en,
  input wire [31:0] i_wdata,
  input wire i_burst_next,
  // system bus answer
  output reg o_wait,
  output reg o_done,
  output reg o_err,
  output reg [31:0] o_rdata,
  // external memory pins
  output reg [NBANK-1:0] o_bank_select_out,
  output reg [3:0] o_byte_lane_strobe,
  output reg o_we_b,
  output reg o_oe_b,
  output reg [23:0] o_addr,
  output reg [31:0] o_data_out,
  output reg o_data_oe,
  input wire [31:0] i_data_in
);
  localparam ST_IDLE = 6'b000001;
  localparam ST_CFG = 6'b000010;
  localparam ST_TURN = 6'b000100;
  localparam ST_ACC = 6'b001000;
  localparam ST_DONE = 6'b010000;
  localparam ST_BEAT = 6'b100000;

  reg [5:0] state_r;
  reg [4:0] cnt_r;
  reg [2:0] bank_r;
  reg [2:0] last_bank_r;
  reg last_rd_r;
  reg wr_r;
  reg [31:0] data_sync1_r;
  reg [31:0] data_sync2_r;
  wire [CFG_W-1:0] cfg;
  wire [2:0] req_bank = i_addr[`SMBC_BANK_HI:`SMBC_BANK_LO];
  // look up the requested bank while idle so its config is ready in ST_CFG
  wire [2:0] cfg_raddr = (state_r == ST_IDLE) ? req_bank : bank_r;
  wire is_ext = (i_addr[`SMBC_BASE_HI:`SMBC_BASE_LO] == `SMBC_BASE_VAL);
  wire [1:0] c_width = cfg[1:0];
  wire c_rd_lanes = cfg[3];
  wire [3:0] c_idle = cfg[7:4];
  wire [4:0] c_rws = cfg[12:8];
  wire [4:0] c_wws = cfg[17:13];
  wire [4:0] c_bfirst = cfg[22:18];
  wire [4:0] c_bnext = cfg[27:23];
  wire c_burst = cfg[28];
  wire c_wprot = cfg[29];
  reg [3:0] lanes;

  smbc_cfg_mem #(.WIDTH(CFG_W), .DEPTH(NBANK), .AW(3)) u_cfg (
    .i_sys_clk(i_sys_clk),
    .i_we(i_cfg_we),
    .i_waddr(i_cfg_bank),
    .i_wdata(i_cfg_data),
    .i_raddr(cfg_raddr),
    .o_rdata(cfg)
  );

  // narrow banks use only the low lanes
  always @* begin
    case (c_width)
      `SMBC_WIDTH_8: lanes = i_byte_en & 4'h1;
      `SMBC_WIDTH_16: lanes = i_byte_en & 4'h3;
      default: lanes = i_byte_en;
    endcase
  end

  // read data is a pin input from outside
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      data_sync1_r <= 32'h0;
      data_sync2_r <= 32'h0;
    end else begin
      data_sync1_r <= i_data_in;
      data_sync2_r <= data_sync1_r;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h0;
      bank_r <= 3'h0;
      last_bank_r <= 3'h0;
      last_rd_r <= 1'b0;
      wr_r <= 1'b0;
      o_wait <= 1'b0;
      o_done <= 1'b0;
      o_err <= 1'b0;
      o_rdata <= 32'h0;
      o_bank_select_out <= 8'h0;
      o_byte_lane_strobe <= 4'h0;
      o_we_b <= 1'b1;
      o_oe_b <= 1'b1;
      o_addr <= 24'h0;
      o_data_out <= 32'h0;
      o_data_oe <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_err <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          o_bank_select_out <= ~i_cs_pol;
          if (i_req) begin
            if (is_ext) begin
              bank_r <= req_bank;
              wr_r <= i_write;
              o_addr <= i_addr[`SMBC_ADDR_HI:0];
              o_data_out <= i_wdata;
              o_wait <= 1'b1;
              state_r <= ST_CFG;
            end else begin
              o_err <= 1'b1;
            end
          end
        end
        ST_CFG: begin
          // config read data now valid for bank_r
          if (wr_r && last_rd_r && (last_bank_r == bank_r)) begin
            cnt_r <= {1'b0, c_idle};
            state_r <= ST_TURN;
          end else begin
            cnt_r <= wr_r ? c_wws : (c_burst ? c_bfirst : c_rws);
            state_r <= ST_ACC;
            o_bank_select_out <= ~i_cs_pol ^ (8'h1 << bank_r);
            o_byte_lane_strobe <= (wr_r || c_rd_lanes) ? lanes : 4'h0;
            o_we_b <= ~(wr_r && !c_wprot);
            o_oe_b <= wr_r;
            o_data_oe <= wr_r && !c_wprot;
          end
        end
        ST_TURN: begin
          if (cnt_r == 5'h0) begin
            cnt_r <= c_wws;
            state_r <= ST_ACC;
            o_bank_select_out <= ~i_cs_pol ^ (8'h1 << bank_r);
            o_byte_lane_strobe <= lanes;
            o_we_b <= c_wprot;
            o_oe_b <= 1'b1;
            o_data_oe <= !c_wprot;
          end else begin
            cnt_r <= cnt_r - 5'h1;
          end
        end
        ST_ACC: begin
          if (cnt_r == 5'h0) begin
            state_r <= ST_DONE;
          end else begin
            cnt_r <= cnt_r - 5'h1;
          end
        end
        ST_DONE: begin
          // two extra edges cover the data synchroniser
          if (cnt_r == 5'h2) begin
            o_rdata <= data_sync2_r;
            o_done <= 1'b1;
            cnt_r <= 5'h0;
            last_bank_r <= bank_r;
            last_rd_r <= !wr_r;
            if (!wr_r && c_burst && i_burst_next) begin
              state_r <= ST_BEAT;
            end else begin
              o_wait <= 1'b0;
              o_bank_select_out <= ~i_cs_pol;
              o_byte_lane_strobe <= 4'h0;
              o_we_b <= 1'b1;
              o_oe_b <= 1'b1;
              o_data_oe <= 1'b0;
              state_r <= ST_IDLE;
            end
          end else begin
            cnt_r <= cnt_r + 5'h1;
          end
        end
        ST_BEAT: begin
          // next sequential beat keeps select and oe asserted
          o_addr <= o_addr + 24'h4;
          cnt_r <= c_bnext;
          state_r <= ST_ACC;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // smbc_ctrl

/* testbench/smbc_mem_model.sv */
`timescale 1ns/100ps
module smbc_mem_model (
  input wire logic i_we_b, i_oe_b,
  input wire logic [3:0] i_lanes,
  input wire logic [23:0] i_addr,
  input wire logic [31:0] i_data,
  output logic [31:0] o_data
);
  logic [31:0] mem [0:15];
  always @*
    if (!i_we_b) for (int k = 0; k < 4; k++) if (i_lanes[k]) mem[i_addr[5:2]][k*8+:8] = i_data[k*8+:8];
  // a released bus shows the inverse so stale data never passes
  assign o_data = i_oe_b ? ~mem[i_addr[5:2]] : mem[i_addr[5:2]];
endmodule // smbc_mem_model

/* testbench/smbc_ctrl_chk.sv */
`timescale 1ns/100ps
module smbc_ctrl_chk #(parameter NBANK = 8) (
  input wire i_sys_clk, i_rst_b, i_req, o_wait, o_done, o_err, o_we_b, o_oe_b, o_data_oe,
  input wire [31:0] i_addr,
  input wire [NBANK-1:0] i_cs_pol, o_bank_select_out,
  input wire [3:0] o_byte_lane_strobe
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_take;
    $rose(o_wait);
  endsequence
  sequence s_answer;
    ##[2:90] o_done;
  endsequence
  answer_bound_a: assert property (s_take |-> s_answer)
    else $error("access not answered");
  base_refuse_a: assert property (i_req && !o_wait && !o_err && i_addr[31:29] != 3'h2 |=> o_err)
    else $error("outside address taken");
  base_take_a: assert property (i_req && !o_wait && !o_err && i_addr[31:29] == 3'h2 |=> o_wait && !o_err)
    else $error("external address refused");
  err_quiet_a: assert property (o_err |-> o_oe_b && o_we_b ##1 !o_err)
    else $error("refusal drove pins");
  one_sel_a: assert property (!o_oe_b || !o_we_b |-> $onehot(o_bank_select_out ~^ i_cs_pol))
    else $error("select count wrong");
  we_excl_a: assert property (!o_we_b |-> o_oe_b && o_data_oe && o_wait)
    else $error("write strobe misplaced");
  oe_free_a: assert property (!o_oe_b |-> !o_data_oe && o_wait)
    else $error("read enable misplaced");
  lane_wr_a: assert property ($fell(o_we_b) |-> o_byte_lane_strobe != 4'h0)
    else $error("write without lanes");
endmodule // smbc_ctrl_chk
bind smbc_ctrl smbc_ctrl_chk #(.NBANK(NBANK)) i_chk (.*);

/* testbench/smbc_ctrl_tb.sv */
`timescale 1ns/100ps
module smbc_ctrl_tb;
  logic i_sys_clk = 0, i_rst_b = 0, i_cfg_we = 0, i_req = 0, i_write = 0, i_burst_next = 0, e;
  logic o_wait, o_done, o_err, o_we_b, o_oe_b, o_data_oe;
  logic [2:0] i_cfg_bank = 0;
  logic [29:0] i_cfg_data = 0;
  logic [7:0] i_cs_pol = 8'ha5, o_bank_select_out;
  logic [3:0] i_byte_en = 4'hf, o_byte_lane_strobe;
  logic [23:0] o_addr;
  logic [31:0] i_addr = 0, i_wdata = 0, i_data_in, o_rdata, o_data_out, rd, sel, ln, ea;
  int fails = 0, checks = 0, cyc, c0, c1;
  always #10 i_sys_clk = ~i_sys_clk;
  smbc_ctrl i_dut (.*);
  smbc_mem_model i_mem (.i_we_b(o_we_b), .i_oe_b(o_oe_b), .i_lanes(o_byte_lane_strobe), .i_addr(o_addr),
    .i_data(o_data_out), .o_data(i_data_in));
  task automatic check(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [29:0] cw(input logic [4:0] rw, ww, input logic [3:0] idl, input logic rl, wp);
    return {wp, 11'h0, ww, rw, idl, rl, 3'h2};
  endfunction
  task automatic cfg(input logic [2:0] b, input logic [29:0] d);
    @(negedge i_sys_clk) {i_cfg_we, i_cfg_bank, i_cfg_data} = {1'b1, b, d};
    @(negedge i_sys_clk) i_cfg_we = 0;
  endtask
  // one access; pin activity is gathered until the answer
  task automatic acc(input logic w, input logic [31:0] a, d);
    @(negedge i_sys_clk) {i_req, i_write, i_addr, i_wdata} = {1'b1, w, a, d};
    @(negedge i_sys_clk) i_req = 0;
    sel = 0;
    ln = 0;
    cyc = 0;
    while (o_done !== 1'b1 && o_err !== 1'b1) begin
      sel |= {24'h0, o_bank_select_out ~^ i_cs_pol};
      ln |= {28'h0, o_byte_lane_strobe};
      if (!o_oe_b || !o_we_b) ea = {8'h0, o_addr};
      @(negedge i_sys_clk) cyc++;
      if (cyc > 200) begin
        fails++;
        conclude;
      end
    end
    e = o_err;
    rd = o_rdata;
    @(negedge i_sys_clk);
  endtask
  task automatic t_banks;
    for (int b = 0; b < 8; b++) begin
      acc(1, {3'h2, b[2:0], b[1:0], 18'h0, b[3:0], 2'h0}, 32'hc0de_0000 + b);
      check(sel, 32'h1 << b);
      check(ea, {26'h0, b[3:0], 2'h0});
    end
    for (int b = 0; b < 8; b++) begin
      acc(0, {3'h2, b[2:0], 20'h0, b[3:0], 2'h0}, 0);
      check(rd, 32'hc0de_0000 + b);
    end
  endtask
  task automatic t_refuse;
    acc(1, 32'h6000_0008, 32'h1);
    check(e, 1);
    acc(0, 32'h0000_0008, 0);
    check(e, 1);
    acc(0, 32'h4000_0008, 0);
    check(rd, 32'hc0de_0002);
  endtask
  task automatic t_protect;
    cfg(7, cw(0, 0, 0, 0, 1));
    acc(1, 32'h5c00_001c, 32'h0bad_0bad);
    acc(0, 32'h5c00_001c, 0);
    check(rd, 32'hc0de_0007);
  endtask
  task automatic t_timing;
    acc(0, 32'h4400_0000, 0);
    c0 = cyc;
    acc(1, 32'h4400_0000, 32'hc0de_0000);
    c1 = cyc;
    cfg(1, cw(9, 31, 15, 0, 0));
    acc(0, 32'h4400_0000, 0);
    check(cyc - c0, 9);
    acc(1, 32'h4400_0000, 32'hc0de_0000);
    check(cyc - c1, 46);
  endtask
  task automatic t_lanes;
    i_byte_en = 4'h9;
    acc(1, 32'h4c00_0000, 0);
    check(ln, 9);
    i_byte_en = 4'h6;
    acc(0, 32'h4c00_0000, 0);
    check(ln, 0);
    check(rd, 32'h00de_0000);
    cfg(3, cw(0, 0, 0, 1, 0));
    acc(0, 32'h4c00_0000, 0);
    check(ln, 6);
  endtask
  task automatic t_burst;
    i_byte_en = 4'hf;
    cfg(4, 30'h0);
    acc(1, 32'h5000_0000, 32'h0);
    check(ln, 1);
    cfg(2, {1'b0, 1'b1, 5'h1, 5'h3, 18'h2});
    i_burst_next = 1;
    @(negedge i_sys_clk) {i_req, i_write, i_addr} = {1'b1, 1'b0, 32'h4800_0004};
    @(negedge i_sys_clk) i_req = 0;
    cyc = 0;
    while (o_done !== 1'b1 && cyc < 200) begin
      @(negedge i_sys_clk) cyc++;
    end
    check(o_rdata, 32'hc0de_0001);
    i_burst_next = 0;
    cyc = 0;
    do begin
      @(negedge i_sys_clk) cyc++;
    end while (o_done !== 1'b1 && cyc < 200);
    check(cyc, 6);
    check(o_rdata, 32'hc0de_0002);
    check(o_wait, 0);
    @(negedge i_sys_clk);
  endtask
  initial begin
    repeat (6) @(negedge i_sys_clk);
    i_rst_b = 1;
    for (int b = 0; b < 8; b++) cfg(b[2:0], cw(0, 0, 0, 0, 0));
    t_banks;
    t_refuse;
    t_protect;
    t_timing;
    t_lanes;
    t_burst;
    conclude;
  end
endmodule // smbc_ctrl_tb
